// ### rtl/cef_params.svh
// cef_params.svh: offsets, bit positions, reset values and masks of the event flags
// assumes: included by bare name from the package and the cef_event_flags module, guarded against repeats
`ifndef CEF_PARAMS_SVH
`define CEF_PARAMS_SVH
// ----------------------------------------------------------------------
// register offsets on the serial register port
// ----------------------------------------------------------------------
`define CEF_OFS_FLAGS_A 8'h25
`define CEF_OFS_FLAGS_B 8'h26
`define CEF_OFS_FLAGS_F 8'h27
`define CEF_OFS_MASK_A 8'h28
`define CEF_OFS_MASK_B 8'h29
`define CEF_OFS_MASK_F 8'h2a
// ----------------------------------------------------------------------
// reset values and defined-bit masks
// ----------------------------------------------------------------------
`define CEF_RST_FLAGS 8'h00
`define CEF_RST_MASK 8'h00
`define CEF_DEF_A 8'heb
`define CEF_DEF_B 8'h9b
`define CEF_DEF_F 8'hfe
`define CEF_ADC_HIDE 8'h7f
// ----------------------------------------------------------------------
// field positions and sync flag latency
// ----------------------------------------------------------------------
`define CEF_A_ADC_DONE 7
`define CEF_B_SYNC 1
`define CEF_F_GATE 1
`define CEF_SYNC_LAT 3
`endif

// ### rtl/cef_pkg.sv
// cef_pkg: types shared by the event flag block and its testbench
// assumes: cef_params.svh is on the include path
package cef_pkg;
	`include "cef_params.svh"
	// ----------------------------------------------------------------------
	// live status from the charger core, same clock domain
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic adc_conv_done; // one-cycle pulse at end of a conversion
		logic adc_continuous_mode; // converter runs continuously
		logic input_current_limit_active;
		logic input_voltage_limit_active;
		logic watchdog_expired_status;
		logic constant_voltage_timer_expired;
		logic [2:0] charge_phase;
		logic input_power_good;
		logic [2:0] thermistor_zone_field;
		logic reverse_mode_active;
		logic [1:0] peak_power_track_field;
		logic input_undervoltage_active;
		logic input_overvoltage_active;
		logic battery_overcurrent_active;
		logic battery_overvoltage_active;
		logic die_overheat_active;
		logic safety_timer_expired;
	} cef_status_t;
	// ----------------------------------------------------------------------
	// register port request
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic rd_en; // one-cycle read strobe
		logic wr_en; // one-cycle write strobe
		logic [7:0] addr;
		logic [7:0] wdata;
	} cef_reg_req_t;
	// ----------------------------------------------------------------------
	// state of the flag block, except its synchroniser and detector flops
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] flags_a;
		logic [7:0] flags_b;
		logic [7:0] flags_f;
		logic [7:0] mask_a;
		logic [7:0] mask_b;
		logic [7:0] mask_f;
		logic [7:0] rd_data;
		logic rd_valid;
		logic int_pulse;
		logic live; // high from the second cycle after reset
	} cef_state_t;
	localparam cef_state_t CEF_ST_RST = '{flags_a: `CEF_RST_FLAGS, flags_b: `CEF_RST_FLAGS,
		flags_f: `CEF_RST_FLAGS, mask_a: `CEF_RST_MASK, mask_b: `CEF_RST_MASK,
		mask_f: `CEF_RST_MASK, rd_data: 8'h00, rd_valid: 1'b0, int_pulse: 1'b0,
		live: 1'b0};
endpackage : cef_pkg

// ### rtl/cef_sync.sv
// cef_sync: two-flop synchroniser for pin levels, one bit per lane
// assumes: inputs are slow levels; no pulse shorter than two clocks
`timescale 1ns/1ps
module cef_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// pin side and clock side
	input wire logic [W-1:0] pin_level,
	output logic [W-1:0] sync_level
);
	typedef struct packed {
		logic [W-1:0] meta; // first stage, read by the second stage only
		logic [W-1:0] sync;
	} cef_sync_st_t;
	cef_sync_st_t st_ff;
	cef_sync_st_t nxt_st;
	// ----------------------------------------------------------------------
	// shift the pin through both stages
	// ----------------------------------------------------------------------
	always_comb begin
		nxt_st.meta = pin_level;
		nxt_st.sync = st_ff.meta;
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign sync_level = st_ff.sync;
endmodule : cef_sync

// ### rtl/cef_evt_det.sv
// cef_evt_det: per-bit rising edge and whole-field change detector
// assumes: level is in the clock domain; events are combinational one-cycle pulses
`timescale 1ns/1ps
module cef_evt_det #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// watched level and events
	input wire logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic chg
);
	typedef struct packed {
		logic armed; // first cycle after reset only captures
		logic [W-1:0] prev;
	} cef_det_st_t;
	cef_det_st_t st_ff;
	cef_det_st_t nxt_st;
	// ----------------------------------------------------------------------
	// compare against last cycle; unarmed keeps a level present at reset quiet
	// ----------------------------------------------------------------------
	always_comb begin
		nxt_st.armed = 1'b1;
		nxt_st.prev = level;
		rise = st_ff.armed ? (level & ~st_ff.prev) : '0;
		chg = st_ff.armed && (level != st_ff.prev);
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule : cef_evt_det

// ### rtl/cef_event_flags.sv
// cef_event_flags: three clear-on-read event flag registers with their mask registers
// assumes: status comes from core logic on clk; two pin levels arrive asynchronously
//
// Operation
// - one-shot conversion done sets flags A bit 7
// - continuous mode reads conversion flag as zero
// - flags read-only; a read clears returned flags
// - entering input current regulation sets A bit 6
// - entering input voltage regulation sets A bit 5
// - watchdog expiry rising edge sets A bit 3
// - constant voltage timer rising sets A bit 1
// - charge phase change sets A bit 0
// - power good toggle sets B bit 7
// - thermistor zone change sets B bit 4
// - reverse mode entry or exit sets B bit 3
// - sync pin status change sets B bit 1
// - peak power track change sets B bit 0
// - input undervoltage entry sets fault bit 7
// - input overvoltage entry sets fault bit 6
// - battery overcurrent entry sets fault bit 5
// - battery overvoltage entry sets fault bit 4
// - thermal shutdown entry sets fault bit 3
// - safety timer rising edge sets fault bit 2
// - gate driver supply fault sets fault bit 1
// - all three flag registers reset to zero
// - mask bit one suppresses interrupt pulse
`timescale 1ns/1ps
`include "cef_params.svh"
module cef_event_flags (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// live status from the charger core
	input wire cef_pkg::cef_status_t status,
	// asynchronous pin levels
	input wire logic switch_clock_sync_input,
	input wire logic gate_driver_supply_pin,
	// serial register port
	input wire cef_pkg::cef_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// interrupt request pulse
	output logic int_pulse
);
	import cef_pkg::*;

	// ----------------------------------------------------------------------
	// state and working signals
	// ----------------------------------------------------------------------
	cef_state_t st_ff; // every register of the block except the synchroniser and detector flops
	cef_state_t nxt_st; // next value, built in one place
	logic [1:0] pin_sync; // synchronised pins: [1] sync pin, [0] gate supply
	logic [10:0] rise_lvl; // levels whose rising edge is an event
	logic [10:0] rise_evt; // one pulse per rising edge
	logic phase_chg; // charge phase moved
	logic pgood_chg; // power good toggled
	logic zone_chg; // thermistor zone moved
	logic rev_chg; // reverse mode toggled
	logic sync_chg; // sync pin status moved
	logic ppt_chg; // peak power tracking moved
	logic adc_evt; // conversion done counted in one-shot mode only
	logic [7:0] set_a; // events aimed at flags A
	logic [7:0] set_b; // events aimed at flags B
	logic [7:0] set_f; // events aimed at the fault flags
	logic [7:0] rd_word; // value the addressed register returns
	logic [7:0] clr_a; // flags A cleared by a read
	logic [7:0] clr_b; // flags B cleared by a read
	logic [7:0] clr_f; // fault flags cleared by a read
	logic unmasked; // some event passes its mask

	// ----------------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------------
	// the pins are not on clk; two flops before any detector looks at them
	cef_sync #(
		.W(2)
	) u_pin_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_level({switch_clock_sync_input, gate_driver_supply_pin}),
		.sync_level(pin_sync)
	);

	// ----------------------------------------------------------------------
	// event detectors
	// ----------------------------------------------------------------------
	// entries into protection and regulation are rising edges of their levels
	assign rise_lvl = {status.input_current_limit_active, status.input_voltage_limit_active,
		status.watchdog_expired_status, status.constant_voltage_timer_expired,
		status.input_undervoltage_active, status.input_overvoltage_active,
		status.battery_overcurrent_active, status.battery_overvoltage_active,
		status.die_overheat_active, status.safety_timer_expired, pin_sync[0]};

	// one instance covers every rising-edge event
	cef_evt_det #(
		.W(11)
	) u_rise (
		.clk(clk),
		.sys_rst(sys_rst),
		.level(rise_lvl),
		.rise(rise_evt),
		.chg()
	);

	// charge phase: any transition counts, whatever the new phase
	cef_evt_det #(
		.W(3)
	) u_phase (
		.clk(clk),
		.sys_rst(sys_rst),
		.level(status.charge_phase),
		.rise(),
		.chg(phase_chg)
	);

	// power good: both directions count
	cef_evt_det #(
		.W(1)
	) u_pgood (
		.clk(clk),
		.sys_rst(sys_rst),
		.level(status.input_power_good),
		.rise(),
		.chg(pgood_chg)
	);

	// thermistor zone: any transition counts
	cef_evt_det #(
		.W(3)
	) u_zone (
		.clk(clk),
		.sys_rst(sys_rst),
		.level(status.thermistor_zone_field),
		.rise(),
		.chg(zone_chg)
	);

	// reverse mode: entry and exit both count
	cef_evt_det #(
		.W(1)
	) u_rev (
		.clk(clk),
		.sys_rst(sys_rst),
		.level(status.reverse_mode_active),
		.rise(),
		.chg(rev_chg)
	);

	// sync pin status, after the synchroniser
	cef_evt_det #(
		.W(1)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.level(pin_sync[1]),
		.rise(),
		.chg(sync_chg)
	);

	// peak power tracking state: any transition counts
	cef_evt_det #(
		.W(2)
	) u_ppt (
		.clk(clk),
		.sys_rst(sys_rst),
		.level(status.peak_power_track_field),
		.rise(),
		.chg(ppt_chg)
	);

	// ----------------------------------------------------------------------
	// event vectors, laid out as the flag registers
	// ----------------------------------------------------------------------
	// continuous conversions never raise the done flag
	assign adc_evt = status.adc_conv_done && !status.adc_continuous_mode;
	// reserved positions are tied low so they can never set
	assign set_a = {adc_evt, rise_evt[10], rise_evt[9], 1'b0, rise_evt[8], 1'b0,
		rise_evt[7], phase_chg};
	assign set_b = {pgood_chg, 2'b00, zone_chg, rev_chg, 1'b0,
		sync_chg, ppt_chg};
	assign set_f = {rise_evt[6:0], 1'b0};

	// ----------------------------------------------------------------------
	// next state: register port, flag latches, interrupt pulse
	// ----------------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		rd_word = 8'h00;
		clr_a = 8'h00;
		clr_b = 8'h00;
		clr_f = 8'h00;
		// read mux; unmapped offsets answer zero
		case (reg_req.addr)
			`CEF_OFS_FLAGS_A: begin
				// the done flag is hidden while converting continuously
				if (status.adc_continuous_mode) begin
					rd_word = st_ff.flags_a & `CEF_ADC_HIDE;
				end else begin
					rd_word = st_ff.flags_a;
				end
				clr_a = reg_req.rd_en ? rd_word : 8'h00;
			end
			`CEF_OFS_FLAGS_B: begin
				rd_word = st_ff.flags_b;
				clr_b = reg_req.rd_en ? rd_word : 8'h00;
			end
			`CEF_OFS_FLAGS_F: begin
				rd_word = st_ff.flags_f;
				clr_f = reg_req.rd_en ? rd_word : 8'h00;
			end
			`CEF_OFS_MASK_A: begin
				rd_word = st_ff.mask_a;
			end
			`CEF_OFS_MASK_B: begin
				rd_word = st_ff.mask_b;
			end
			`CEF_OFS_MASK_F: begin
				rd_word = st_ff.mask_f;
			end
			default: begin
				rd_word = 8'h00;
			end
		endcase
		// read answer is registered; data hold between reads
		if (reg_req.rd_en) begin
			nxt_st.rd_data = rd_word;
		end
		nxt_st.rd_valid = reg_req.rd_en;
		// set is applied after clear, so a same-cycle event survives the read
		nxt_st.flags_a = (st_ff.flags_a & ~clr_a) | set_a;
		nxt_st.flags_b = (st_ff.flags_b & ~clr_b) | set_b;
		nxt_st.flags_f = (st_ff.flags_f & ~clr_f) | set_f;
		// writes reach the masks only; flag offsets ignore them
		if (reg_req.wr_en) begin
			case (reg_req.addr)
				`CEF_OFS_MASK_A: begin
					nxt_st.mask_a = reg_req.wdata & `CEF_DEF_A;
				end
				`CEF_OFS_MASK_B: begin
					nxt_st.mask_b = reg_req.wdata & `CEF_DEF_B;
				end
				`CEF_OFS_MASK_F: begin
					nxt_st.mask_f = reg_req.wdata & `CEF_DEF_F;
				end
				default: begin
					nxt_st.mask_a = st_ff.mask_a;
				end
			endcase
		end
		// a masked event still latches its flag, it only skips the pulse
		unmasked = |(set_a & ~st_ff.mask_a) || |(set_b & ~st_ff.mask_b)
			|| |(set_f & ~st_ff.mask_f);
		nxt_st.int_pulse = unmasked;
		nxt_st.live = 1'b1;
	end

	// ----------------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff <= CEF_ST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs come straight from the state register
	assign reg_rdata = st_ff.rd_data;
	assign reg_rvalid = st_ff.rd_valid;
	assign int_pulse = st_ff.int_pulse;

	// ----------------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// read of a given flag register in this cycle
	sequence s_rd_a;
		reg_req.rd_en && reg_req.addr == `CEF_OFS_FLAGS_A;
	endsequence
	// pin change after the detectors are armed
	sequence s_sync_pin_move;
		st_ff.live && $changed(switch_clock_sync_input);
	endsequence

	property p_adc_set;
		status.adc_conv_done && !status.adc_continuous_mode |=> st_ff.flags_a[`CEF_A_ADC_DONE];
	endproperty
	a_adc_set: assert property (p_adc_set) else $error("done flag not set");

	property p_adc_hidden;
		s_rd_a ##0 status.adc_continuous_mode |=> reg_rvalid && !reg_rdata[`CEF_A_ADC_DONE];
	endproperty
	a_adc_hidden: assert property (p_adc_hidden) else $error("done flag visible");

	property p_read_clear;
		s_rd_a ##0 set_a == 8'h00 |=> (st_ff.flags_a & reg_rdata) == 8'h00;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read did not clear");

	// a flag already pending must not count as a miss, so look at the level, not its edge
	property p_chg_rise;
		st_ff.live && $rose(status.input_current_limit_active) |=> st_ff.flags_a[6];
	endproperty
	a_chg_rise: assert property (p_chg_rise) else $error("regulation flag missed");

	property p_rise_group;
		st_ff.live && $rose(status.input_voltage_limit_active) ##0 !st_ff.flags_a[5]
			|=> st_ff.flags_a[5];
	endproperty
	a_rise_group: assert property (p_rise_group) else $error("voltage flag missed");

	property p_wd;
		st_ff.live && $rose(status.watchdog_expired_status) |=> st_ff.flags_a[3];
	endproperty
	a_wd: assert property (p_wd) else $error("watchdog flag missed");

	property p_phase;
		st_ff.live && $changed(status.charge_phase) |=> st_ff.flags_a[0];
	endproperty
	a_phase: assert property (p_phase) else $error("phase flag missed");

	property p_pgood;
		st_ff.live && $changed(status.input_power_good) |=> st_ff.flags_b[7];
	endproperty
	a_pgood: assert property (p_pgood) else $error("power good flag missed");

	property p_sync_pin;
		s_sync_pin_move |-> ##`CEF_SYNC_LAT st_ff.flags_b[`CEF_B_SYNC];
	endproperty
	a_sync_pin: assert property (p_sync_pin) else $error("sync flag missed");

	property p_gate_pin;
		st_ff.live && $rose(gate_driver_supply_pin) |-> ##3 st_ff.flags_f[`CEF_F_GATE];
	endproperty
	a_gate_pin: assert property (p_gate_pin) else $error("gate flag missed");

	property p_faults;
		st_ff.live |=> (st_ff.flags_f[7:2] & $past(set_f[7:2])) == $past(set_f[7:2]);
	endproperty
	a_faults: assert property (p_faults) else $error("fault flag missed");

	property p_reset_zero;
		@(posedge clk) disable iff (1'b0) sys_rst |=> st_ff.flags_a == 8'h00
			&& st_ff.flags_b == 8'h00 && st_ff.flags_f == 8'h00;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("flags not reset");

	property p_int_gate;
		st_ff.live |=> int_pulse == ($past((set_a & ~st_ff.mask_a) != 8'h00)
			|| $past((set_b & ~st_ff.mask_b) != 8'h00) || $past((set_f & ~st_ff.mask_f) != 8'h00));
	endproperty
	a_int_gate: assert property (p_int_gate) else $error("interrupt gating wrong");

	property p_reserved;
		(st_ff.flags_a & ~`CEF_DEF_A) == 8'h00 && (st_ff.flags_b & ~`CEF_DEF_B) == 8'h00
			&& (st_ff.flags_f & ~`CEF_DEF_F) == 8'h00 && (st_ff.mask_f & ~`CEF_DEF_F) == 8'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");

	property p_keep_event;
		s_rd_a ##0 set_a[6] |=> st_ff.flags_a[6];
	endproperty
	a_keep_event: assert property (p_keep_event) else $error("event lost on read");
endmodule : cef_event_flags

// ### verification/cef_event_flags_tb.sv
// cef_event_flags_tb: self-checking bench for the clear-on-read event flag block
// assumes: cef_pkg compiled first; all stimulus driven at the falling clock edge
`timescale 1ns/1ps
module cef_event_flags_tb;
	import cef_pkg::*;
	// ----------------------------------------------------------------------
	// signals and counters
	// ----------------------------------------------------------------------
	logic clk;
	logic sys_rst;
	cef_status_t status;
	logic switch_clock_sync_input;
	logic gate_driver_supply_pin;
	cef_reg_req_t reg_req;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic int_pulse;
	int num_errors;
	int samples_checked;
	// flag bit of each core event, in the order that set_evt numbers them
	logic [7:0] ev_bit [15] = '{8'h40, 8'h20, 8'h08, 8'h02, 8'h01, 8'h80, 8'h10, 8'h08,
		8'h01, 8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04};

	cef_event_flags cef_event_flags_inst (
		.clk(clk),
		.sys_rst(sys_rst),
		.status(status),
		.switch_clock_sync_input(switch_clock_sync_input),
		.gate_driver_supply_pin(gate_driver_supply_pin),
		.reg_req(reg_req),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid),
		.int_pulse(int_pulse)
	);

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ----------------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// waits an edge first so back-to-back calls never drive rd_en twice in one step
	task automatic expect_rd(input string what, input logic [7:0] addr, input logic [7:0] exp);
		@(negedge clk);
		reg_req.rd_en = 1'b1;
		reg_req.addr = addr;
		@(negedge clk);
		reg_req.rd_en = 1'b0;
		check(what, (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx, exp);
	endtask : expect_rd

	task automatic wr(input logic [7:0] addr, input logic [7:0] d);
		@(negedge clk);
		reg_req.wr_en = 1'b1;
		reg_req.addr = addr;
		reg_req.wdata = d;
		@(negedge clk);
		reg_req.wr_en = 1'b0;
	endtask : wr

	// moves one core status source; fields change value both ways
	task automatic set_evt(input int k, input logic v);
		case (k)
			0: status.input_current_limit_active = v;
			1: status.input_voltage_limit_active = v;
			2: status.watchdog_expired_status = v;
			3: status.constant_voltage_timer_expired = v;
			4: status.charge_phase = v ? 3'h5 : 3'h2;
			5: status.input_power_good = v;
			6: status.thermistor_zone_field = v ? 3'h3 : 3'h6;
			7: status.reverse_mode_active = v;
			8: status.peak_power_track_field = v ? 2'h2 : 2'h1;
			9: status.input_undervoltage_active = v;
			10: status.input_overvoltage_active = v;
			11: status.battery_overcurrent_active = v;
			12: status.battery_overvoltage_active = v;
			13: status.die_overheat_active = v;
			default: status.safety_timer_expired = v;
		endcase
	endtask : set_evt

	// ----------------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------------
	task automatic test_reset_values;
		for (int a = 8'h25; a < 8'h2b; a++) begin
			expect_rd("reset value", 8'(a), 8'h00);
		end
		$display("test reset_values done");
	endtask : test_reset_values

	// each event: pulse, flag, clear on read, then the opposite edge
	task automatic test_core_events;
		logic [7:0] ofs;
		for (int k = 0; k < 15; k++) begin
			ofs = (k < 5) ? 8'h25 : (k < 9) ? 8'h26 : 8'h27;
			@(negedge clk);
			set_evt(k, 1'b1);
			@(negedge clk);
			check("pulse on event", {7'h00, int_pulse}, 8'h01);
			@(negedge clk);
			check("pulse one cycle", {7'h00, int_pulse}, 8'h00);
			expect_rd("flag set", ofs, ev_bit[k]);
			expect_rd("flag cleared", ofs, 8'h00);
			set_evt(k, 1'b0);
			// only fields and toggles flag the falling side
			expect_rd("back edge", ofs, (k > 3 && k < 9) ? ev_bit[k] : 8'h00);
		end
		$display("test core_events done");
	endtask : test_core_events

	task automatic test_adc;
		@(negedge clk);
		status.adc_conv_done = 1'b1;
		@(negedge clk);
		status.adc_conv_done = 1'b0;
		expect_rd("one-shot done", 8'h25, 8'h80);
		expect_rd("done cleared", 8'h25, 8'h00);
		status.adc_continuous_mode = 1'b1;
		@(negedge clk);
		status.adc_conv_done = 1'b1;
		@(negedge clk);
		status.adc_conv_done = 1'b0;
		expect_rd("continuous done", 8'h25, 8'h00);
		status.adc_continuous_mode = 1'b0;
		expect_rd("continuous ignored", 8'h25, 8'h00);
		// a pending done flag is hidden while continuous, and survives that read
		@(negedge clk);
		status.adc_conv_done = 1'b1;
		@(negedge clk);
		status.adc_conv_done = 1'b0;
		status.adc_continuous_mode = 1'b1;
		expect_rd("pending hidden", 8'h25, 8'h00);
		status.adc_continuous_mode = 1'b0;
		expect_rd("pending kept", 8'h25, 8'h80);
		$display("test adc done");
	endtask : test_adc

	// pins cross a synchroniser, so allow five cycles
	task automatic test_pins;
		@(negedge clk);
		switch_clock_sync_input = 1'b1;
		gate_driver_supply_pin = 1'b1;
		repeat (5) @(negedge clk);
		expect_rd("sync rise", 8'h26, 8'h02);
		expect_rd("gate rise", 8'h27, 8'h02);
		switch_clock_sync_input = 1'b0;
		gate_driver_supply_pin = 1'b0;
		repeat (5) @(negedge clk);
		expect_rd("sync fall", 8'h26, 8'h02);
		expect_rd("gate fall", 8'h27, 8'h00);
		$display("test pins done");
	endtask : test_pins

	task automatic test_access;
		@(negedge clk);
		status.watchdog_expired_status = 1'b1;
		wr(8'h25, 8'hff);
		wr(8'h26, 8'hff);
		wr(8'h27, 8'hff);
		expect_rd("flags a unwritten", 8'h25, 8'h08);
		expect_rd("flags b unwritten", 8'h26, 8'h00);
		expect_rd("flags f unwritten", 8'h27, 8'h00);
		wr(8'h28, 8'hff);
		wr(8'h29, 8'hff);
		wr(8'h2a, 8'hff);
		expect_rd("mask a", 8'h28, 8'heb);
		expect_rd("mask b", 8'h29, 8'h9b);
		expect_rd("mask f", 8'h2a, 8'hfe);
		expect_rd("unmapped", 8'h30, 8'h00);
		status.input_undervoltage_active = 1'b1;
		@(negedge clk);
		check("masked pulse", {7'h00, int_pulse}, 8'h00);
		expect_rd("masked flag", 8'h27, 8'h80);
		status.input_undervoltage_active = 1'b0;
		status.watchdog_expired_status = 1'b0;
		wr(8'h2a, 8'h00);
		$display("test access done");
	endtask : test_access

	// a pending flag read on the same edge as its next event stays set after the read
	task automatic test_race_and_reset;
		@(negedge clk);
		status.die_overheat_active = 1'b1;
		@(negedge clk);
		status.die_overheat_active = 1'b0;
		@(negedge clk);
		status.die_overheat_active = 1'b1;
		reg_req.rd_en = 1'b1;
		reg_req.addr = 8'h27;
		@(negedge clk);
		reg_req.rd_en = 1'b0;
		check("race read", (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx, 8'h08);
		expect_rd("race kept", 8'h27, 8'h08);
		status.die_overheat_active = 1'b0;
		// leave a flag set and a level high across reset: neither may survive it
		status.input_overvoltage_active = 1'b1;
		@(negedge clk);
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		expect_rd("mid-run reset", 8'h27, 8'h00);
		expect_rd("mask after reset", 8'h28, 8'h00);
		status.input_overvoltage_active = 1'b0;
		$display("test race_and_reset done");
	endtask : test_race_and_reset

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run

	// ----------------------------------------------------------------------
	// main sequence and hang guard
	// ----------------------------------------------------------------------
	initial begin
		num_errors = 0;
		samples_checked = 0;
		status = '0;
		switch_clock_sync_input = 1'b0;
		gate_driver_supply_pin = 1'b0;
		reg_req = '0;
		sys_rst = 1'b1;
		repeat (12) @(negedge clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge clk);
		test_reset_values();
		test_core_events();
		test_adc();
		test_pins();
		test_access();
		test_race_and_reset();
		complete_run();
	end

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		complete_run();
	end
endmodule : cef_event_flags_tb
